// ### hdl/sdrm_pkg.sv
// Package with register map, field positions and reset values of the supply drop monitor.
package sdrm_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] STATUS_OFS = 8'h00;   // Read-only status word.
   localparam logic [7:0] CONFIG_OFS = 8'h04;   // Option configuration word.

   // ---------------------------------------------------------------
   // Status fields
   // ---------------------------------------------------------------
   localparam int FLAG_POS   = 0;               // Low supply flag.
   localparam int HOLD_POS   = 1;               // Low supply reset under way.
   localparam int PIN_POS    = 2;               // Sampled level of the reset pin.

   // ---------------------------------------------------------------
   // Configuration fields and their values after reset
   // ---------------------------------------------------------------
   localparam int PWRD_POS   = 0;               // Monitor power disable.
   localparam int RSTD_POS   = 1;               // Monitor reset disable.
   localparam int STOP_POS   = 2;               // Monitor stop enable.
   localparam int TRIP_POS   = 3;               // Trip level select, 1 selects 5 V.
   localparam logic PWRD_RST = 1'b0;
   localparam logic RSTD_RST = 1'b0;
   localparam logic STOP_RST = 1'b0;
   localparam logic TRIP_RST = 1'b0;
   localparam logic FLAG_RST = 1'b0;

   // ---------------------------------------------------------------
   // Bus responses and reset hold states
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      HOLD_IDLE   = 2'b01,
      HOLD_ACTIVE = 2'b10
   } sdrm_hold_type;

endpackage : sdrm_pkg

// ### hdl/sdrm_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module sdrm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // -----------------------------------------------------------------
   // Synchroniser chain
   // -----------------------------------------------------------------
   // The first stage feeds only the second stage, so metastability settles there.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

   initial begin
      if (WIDTH < 1) begin
         $error("Synchroniser width must be at least one.");
      end
   end

endmodule : sdrm_sync

// ### hdl/sdrm_monitor.sv
// Supply drop reset monitor: comparator conditioning, reset hold and register slave.
//
// Contract
// - Monitor enabled straight out of reset.
// - Monitor only while power disable is zero.
// - Falling trip resets unless reset disable set.
// - Stop mode needs stop enable set.
// - Trip select one picks 5 V thresholds.
// - Power-on reset returns trip select to 3 V.
// - Selecting 5 V below rising level resets.
// - Reset held until supply above rising level.
// - Flag follows the comparator outputs.
// - Reset pin driven low during low reset.
// - Flag one below, zero above, else holds.
// - Any system reset clears the flag.
// - No interrupt; flag and reset only.
// - Monitor runs in wait; reset wakes it.
// - Stop enable keeps monitor in stop; wakes.
`timescale 1ns/1ps
module sdrm_monitor #(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              por,
   input  wire logic              wait_mode,
   input  wire logic              stop_mode,
   input  wire logic              cmp_below_fall_3v,
   input  wire logic              cmp_above_rise_3v,
   input  wire logic              cmp_below_fall_5v,
   input  wire logic              cmp_above_rise_5v,
   output logic                   trip_level_select,
   output logic                   monitor_active,
   output logic                   low_supply_reset,
   input  wire logic              rst_pin_in,
   output logic                   rst_pin_out,
   output logic                   rst_pin_oe_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [4:0]              sync_levels;
   logic                    below_3v;
   logic                    above_3v;
   logic                    below_5v;
   logic                    above_5v;
   logic                    pin_level;
   logic                    below_sel;
   logic                    above_sel;
   logic                    power_disable;
   logic                    reset_disable;
   logic                    stop_enable;
   logic                    low_supply_flag;
   sdrm_pkg::sdrm_hold_type hold_state;
   sdrm_pkg::sdrm_hold_type next_hold_state;
   logic                    in_hold;
   logic                    raise_5v;
   logic                    aw_held;
   logic                    w_held;
   logic [ADDR_W-1:0]       aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    do_write;
   logic [1:0]              wr_sel;
   logic [1:0]              rd_sel;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   initial begin
      if (ADDR_W < 3 || ADDR_W > 32) begin
         $error("Address width must lie between 3 and 32 bits.");
      end
   end

   // Selects one register from a byte address; bit 0 is status, bit 1 configuration.
   function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
      logic [1:0] sel;
      sel    = 2'b00;
      sel[0] = (addr == ADDR_W'(sdrm_pkg::STATUS_OFS));
      sel[1] = (addr == ADDR_W'(sdrm_pkg::CONFIG_OFS));
      return sel;
   endfunction : reg_select

   // -----------------------------------------------------------------
   // Comparator and pin synchronisation
   // -----------------------------------------------------------------
   // All comparator outputs and the pin level cross into the bus clock here.
   sdrm_sync #(
      .WIDTH    (5)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({rst_pin_in, cmp_above_rise_5v, cmp_below_fall_5v,
                  cmp_above_rise_3v, cmp_below_fall_3v}),
      .sync_out (sync_levels)
   );

   assign below_3v  = sync_levels[0];
   assign above_3v  = sync_levels[1];
   assign below_5v  = sync_levels[2];
   assign above_5v  = sync_levels[3];
   assign pin_level = sync_levels[4];

   // Threshold pair picked by the trip level select bit.
   assign below_sel = trip_level_select ? below_5v : below_3v;
   assign above_sel = trip_level_select ? above_5v : above_3v;

   // Monitor runs unless powered down, and in stop mode only when allowed; wait mode
   // does not stop it.
   assign monitor_active = !power_disable && (!stop_mode || stop_enable);

   // -----------------------------------------------------------------
   // Register bus write path
   // -----------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_sel        = reg_select(aw_addr);

   // Address and data are caught in either order and held until the response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response, an error for an unmapped address.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sdrm_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel != 2'b00) ? sdrm_pkg::RESP_OKAY : sdrm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Configuration register
   // -----------------------------------------------------------------
   // System reset leaves the monitor and its reset enabled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_disable <= sdrm_pkg::PWRD_RST;
         reset_disable <= sdrm_pkg::RSTD_RST;
         stop_enable   <= sdrm_pkg::STOP_RST;
      end else if (do_write && wr_sel[1] && w_strb[0]) begin
         power_disable <= w_data[sdrm_pkg::PWRD_POS];
         reset_disable <= w_data[sdrm_pkg::RSTD_POS];
         stop_enable   <= w_data[sdrm_pkg::STOP_POS];
      end
   end

   // Trip level survives system reset and falls back to 3 V only on power-on reset.
   always_ff @(posedge aclk) begin
      if (por) begin
         trip_level_select <= sdrm_pkg::TRIP_RST;
      end else if (do_write && wr_sel[1] && w_strb[0]) begin
         trip_level_select <= w_data[sdrm_pkg::TRIP_POS];
      end
   end

   // A write raising the trip level to 5 V while not above the 5 V rising level.
   assign raise_5v = do_write && wr_sel[1] && w_strb[0] && w_data[sdrm_pkg::TRIP_POS]
                     && !trip_level_select && !above_5v;

   // -----------------------------------------------------------------
   // Low supply flag
   // -----------------------------------------------------------------
   // Flag sets below the falling level, clears above the rising level and holds between.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_supply_flag <= sdrm_pkg::FLAG_RST;
      end else if (monitor_active && below_sel) begin
         low_supply_flag <= 1'b1;
      end else if (monitor_active && above_sel) begin
         low_supply_flag <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Reset hold state machine
   // -----------------------------------------------------------------
   // Only power-on reset clears the hold, since the held reset itself resets the system.
   always_ff @(posedge aclk) begin
      if (por) begin
         hold_state <= sdrm_pkg::HOLD_IDLE;
      end else begin
         hold_state <= next_hold_state;
      end
   end

   // Trips on the falling level or a raise to 5 V; leaves only above the rising level.
   always_comb begin
      next_hold_state = hold_state;
      case (hold_state)
         sdrm_pkg::HOLD_IDLE: begin
            if (monitor_active && !reset_disable && (below_sel || raise_5v)) begin
               next_hold_state = sdrm_pkg::HOLD_ACTIVE;
            end
         end
         sdrm_pkg::HOLD_ACTIVE: begin
            // A raise to 5 V in the same cycle keeps the hold, as it would re-enter at once.
            if (above_sel && !raise_5v) begin
               next_hold_state = sdrm_pkg::HOLD_IDLE;
            end
         end
         default: begin
            next_hold_state = sdrm_pkg::HOLD_IDLE;
         end
      endcase
   end

   assign in_hold = (hold_state == sdrm_pkg::HOLD_ACTIVE);

   // The reset request is the only event out of the block; it also wakes the core.
   assign low_supply_reset = in_hold;

   // Open-drain reset pin pulled low for the whole hold.
   assign rst_pin_out  = 1'b0;
   assign rst_pin_oe_n = !in_hold;

   // -----------------------------------------------------------------
   // Register bus read path
   // -----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_sel        = reg_select(s_axi_araddr);

   // Read data answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= sdrm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= sdrm_pkg::RESP_OKAY;
         if (rd_sel[0]) begin
            s_axi_rdata[sdrm_pkg::FLAG_POS] <= low_supply_flag;
            s_axi_rdata[sdrm_pkg::HOLD_POS] <= in_hold;
            s_axi_rdata[sdrm_pkg::PIN_POS]  <= pin_level;
         end else if (rd_sel[1]) begin
            s_axi_rdata[sdrm_pkg::PWRD_POS] <= power_disable;
            s_axi_rdata[sdrm_pkg::RSTD_POS] <= reset_disable;
            s_axi_rdata[sdrm_pkg::STOP_POS] <= stop_enable;
            s_axi_rdata[sdrm_pkg::TRIP_POS] <= trip_level_select;
         end else begin
            s_axi_rresp <= sdrm_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // A system reset leaves the monitor enabled with resets allowed.
   property p_enabled_after_reset;
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> !power_disable && !reset_disable;
   endproperty
   a_enabled_after_reset : assert property (p_enabled_after_reset)
      else $error("Monitor not enabled after reset.");

   // Power disable keeps the flag from reacting.
   property p_power_off;
      @(posedge aclk) disable iff (!aresetn || por)
      power_disable |=> $stable(low_supply_flag);
   endproperty
   a_power_off : assert property (p_power_off)
      else $error("Flag changed while the monitor was powered down.");

   // A falling trip with resets enabled enters the hold on the next edge.
   property p_trip_reset;
      @(posedge aclk) disable iff (por)
      monitor_active && !reset_disable && below_sel |=> in_hold;
   endproperty
   a_trip_reset : assert property (p_trip_reset)
      else $error("Falling trip did not raise the low supply reset.");

   // Stop mode without stop enable switches the monitor off.
   property p_stop_off;
      @(posedge aclk) disable iff (!aresetn)
      stop_mode && !stop_enable |-> !monitor_active;
   endproperty
   a_stop_off : assert property (p_stop_off)
      else $error("Monitor active in stop mode without stop enable.");

   // Wait mode on its own never switches the monitor off.
   property p_wait_active;
      @(posedge aclk) disable iff (!aresetn)
      wait_mode && !stop_mode && !power_disable |-> monitor_active;
   endproperty
   a_wait_active : assert property (p_wait_active)
      else $error("Monitor switched off in wait mode.");

   // Power-on reset returns the trip level to 3 V and clears the hold.
   property p_por_3v;
      @(posedge aclk) disable iff (1'b0)
      por |=> !trip_level_select && !in_hold;
   endproperty
   a_por_3v : assert property (p_por_3v)
      else $error("Power-on reset did not restore 3 V trip level.");

   // Writing 5 V mode while not above the 5 V rising level enters the hold.
   sequence s_raise_5v_low;
      monitor_active && !reset_disable && do_write && wr_sel[1] && w_strb[0]
         && w_data[sdrm_pkg::TRIP_POS] && !trip_level_select && !above_5v;
   endsequence
   property p_raise_5v;
      @(posedge aclk) disable iff (por)
      s_raise_5v_low |=> in_hold && trip_level_select;
   endproperty
   a_raise_5v : assert property (p_raise_5v)
      else $error("Raising trip level to 5 V below threshold did not reset.");

   // The hold stays until the selected rising level is passed.
   property p_hold_until_rise;
      @(posedge aclk) disable iff (por)
      in_hold && !above_sel |=> in_hold;
   endproperty
   a_hold_until_rise : assert property (p_hold_until_rise)
      else $error("Reset released below the rising level.");

   // The pin is pulled low whenever the reset is held.
   property p_pin_low;
      @(posedge aclk) disable iff (por)
      low_supply_reset |-> !rst_pin_oe_n && !rst_pin_out;
   endproperty
   a_pin_low : assert property (p_pin_low)
      else $error("Reset pin not driven low during low supply reset.");

   // Between the thresholds the flag keeps its value at the next edge.
   sequence s_in_band;
      monitor_active && !below_sel && !above_sel;
   endsequence
   property p_band_hold;
      @(posedge aclk) disable iff (!aresetn)
      s_in_band |=> $stable(low_supply_flag);
   endproperty
   a_band_hold : assert property (p_band_hold)
      else $error("Flag changed inside the hysteresis band.");

   // Any system reset clears the flag.
   property p_reset_clears_flag;
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> !low_supply_flag;
   endproperty
   a_reset_clears_flag : assert property (p_reset_clears_flag)
      else $error("Flag not cleared by system reset.");

endmodule : sdrm_monitor

// ### tb/sdrm_monitor_tb.sv
// Self-checking testbench of the supply drop reset monitor.
`timescale 1ns/1ps
module sdrm_monitor_tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        aclk, aresetn, por, wait_mode, stop_mode;
   logic        cmp_below_fall_3v, cmp_above_rise_3v;
   logic        cmp_below_fall_5v, cmp_above_rise_5v;
   logic        trip_level_select, monitor_active, low_supply_reset;
   logic        rst_pin_in, rst_pin_out, rst_pin_oe_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] rd;
   logic [1:0]  rs;
   int          err_total, check_count, cycles;

   // The reset pin has a pull-up, so it reads high unless the block drives it.
   assign rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;

   sdrm_monitor #(.ADDR_W(8)) uut (.*);

   // Clock of 25 ns period.
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Cycle counter that cuts a hang short.
   always @(posedge aclk) begin
      cycles++;
      if (cycles >= 5000) begin
         err_total++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Compares a value and counts the result.
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // Waits some edges and stops at the falling edge, where outputs are settled.
   task wait_cyc(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : wait_cyc

   // Drives the comparator levels at a rising edge.
   task cmp(input logic bf3, input logic ar3, input logic bf5, input logic ar5);
      @(posedge aclk);
      cmp_below_fall_3v <= bf3;
      cmp_above_rise_3v <= ar3;
      cmp_below_fall_5v <= bf5;
      cmp_above_rise_5v <= ar5;
   endtask : cmp

   // AXI4-Lite write; readiness seen at the falling edge holds up to the next rise.
   task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok, a_t, w_t, b_t;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'h1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(negedge aclk);
         a_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         @(posedge aclk);
         if (a_t) begin
            s_axi_awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (w_t) begin
            s_axi_wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do begin
         @(negedge aclk);
         b_t = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end while (!b_t);
      s_axi_bready <= 1'b0;
   endtask : axi_write

   // AXI4-Lite read.
   task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic a_t, r_t;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge aclk);
         a_t = s_axi_arvalid & s_axi_arready;
         @(posedge aclk);
      end while (!a_t);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         r_t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (!r_t);
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Reads a register and compares the word and an OKAY response.
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      axi_read(a, rd, rs);
      chk(rd, exp, msg);
      chk({30'h0, rs}, {30'h0, sdrm_pkg::RESP_OKAY}, "read response");
   endtask : rd_chk

   // Writes the configuration word.
   task cfg(input logic [31:0] d);
      axi_write(sdrm_pkg::CONFIG_OFS, d, rs);
      chk({30'h0, rs}, {30'h0, sdrm_pkg::RESP_OKAY}, "write response");
   endtask : cfg

   // Prints the counts and the verdict, then ends the run.
   task wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {err_total, check_count, cycles} = '0;
      {aresetn, stop_mode, wait_mode, cmp_below_fall_3v, cmp_below_fall_5v} = '0;
      {por, cmp_above_rise_3v, cmp_above_rise_5v} = 3'b111;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      por     <= 1'b0;
      wait_cyc(3);
      chk(monitor_active, 1'b1, "active out of reset");
      chk(trip_level_select, 1'b0, "3 V after power-on");
      chk({low_supply_reset, rst_pin_oe_n}, 2'b01, "no reset at start");
      rd_chk(sdrm_pkg::CONFIG_OFS, 32'h0, "config reset value");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "status reset value");
      $display("test reset done");
      // Falling trip, hysteresis hold and release.
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk({low_supply_reset, rst_pin_oe_n}, 2'b10, "trip drives reset");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h3, "flag and pin low");
      cmp(1'b0, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b1, "held inside band");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h3, "flag holds in band");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      wait_cyc(5);
      chk({low_supply_reset, rst_pin_oe_n}, 2'b01, "released above rise");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "flag clears above");
      $display("test trip done");
      // Polled operation with resets disabled.
      cfg(32'h2);
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b0, "no reset when disabled");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h5, "flag polled low");
      cmp(1'b0, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h5, "polled flag holds");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      wait_cyc(5);
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "polled flag clears");
      $display("test polled done");
      // Power disable switches the monitor off.
      cfg(32'h1);
      wait_cyc(1);
      chk(monitor_active, 1'b0, "power disable");
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b0, "off monitor no reset");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "off monitor flag frozen");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test power disable done");
      // Stop and wait modes.
      cfg(32'h0);
      @(posedge aclk);
      stop_mode <= 1'b1;
      wait_cyc(1);
      chk(monitor_active, 1'b0, "stop without enable");
      cfg(32'h4);
      @(posedge aclk);
      wait_mode <= 1'b1;
      wait_cyc(1);
      chk(monitor_active, 1'b1, "stop with enable");
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b1, "reset wakes from stop");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      @(posedge aclk);
      stop_mode <= 1'b0;
      wait_cyc(5);
      chk({low_supply_reset, monitor_active}, 2'b01, "active in wait");
      @(posedge aclk);
      wait_mode <= 1'b0;
      $display("test low power done");
      // Raising the trip level below the 5 V rising threshold.
      cmp(1'b0, 1'b1, 1'b0, 1'b0);
      wait_cyc(3);
      cfg(32'h8);
      wait_cyc(0);
      chk({trip_level_select, low_supply_reset}, 2'b11, "5 V select resets");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b0, "5 V rise releases");
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      chk(low_supply_reset, 1'b0, "3 V levels ignored in 5 V");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      @(posedge aclk);
      por <= 1'b1;
      @(posedge aclk);
      por <= 1'b0;
      wait_cyc(1);
      chk(trip_level_select, 1'b0, "power-on returns to 3 V");
      $display("test trip select done");
      // System reset clears a held flag.
      cfg(32'h2);
      cmp(1'b1, 1'b0, 1'b0, 1'b1);
      cmp(1'b0, 1'b0, 1'b0, 1'b1);
      wait_cyc(5);
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h5, "flag set before reset");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_cyc(1);
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "reset clears flag");
      rd_chk(sdrm_pkg::CONFIG_OFS, 32'h0, "reset clears config");
      cmp(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test system reset done");
      // Bus corner cases.
      axi_read(8'h10, rd, rs);
      chk({rd[29:0], rs}, {30'h0, sdrm_pkg::RESP_SLVERR}, "unmapped read");
      axi_write(sdrm_pkg::STATUS_OFS, 32'hff, rs);
      chk({30'h0, rs}, {30'h0, sdrm_pkg::RESP_OKAY}, "status write okay");
      rd_chk(sdrm_pkg::STATUS_OFS, 32'h4, "status is read-only");
      $display("test bus done");
      wrap_up();
   end
endmodule : sdrm_monitor_tb
